// ### bench/hscc_host.sv
// host model: issues serial diagnosis frames on the link pins
`timescale 1ns/10ps
module hscc_host (
  input wire logic go,
  output logic sclk,
  output logic cs_n,
  output logic busy
);
  // ----------------------------------------------------------------
  // frame generator
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    busy = 1'h0;
  end

  // serial clock stands still low outside frames; odd offset keeps phase loose
  always @(posedge go) begin
    busy = 1'h1;
    #13 cs_n = 1'h0;
    repeat (8) begin
      #40 sclk = 1'h1;
      #40 sclk = 1'h0;
    end
    #40 cs_n = 1'h1;
    busy = 1'h0;
  end
endmodule

// ### bench/tb.sv
// self-checking testbench for the high-side channel control block
`timescale 1ns/10ps
module tb;
  typedef logic [hscc_pkg::NUM_CH-1:0] hscc_vec_t;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic srst = 1'h1;
  hscc_vec_t pin = '0, ot = '0, dyn = '0, inv = '0, ovl = '0;
  logic gnd = 1'h0, go = 1'h0, rv = 1'h0, rw = 1'h0, bank = 1'h0;
  logic [hscc_pkg::ADDR_W-1:0] addr = '0;
  logic [hscc_pkg::DATA_W-1:0] wd = '0, rdata;
  logic rvalid, mode, sclk, cs_n, busy;
  hscc_vec_t outp, err, lat;
  int miscompares = 0;
  int checks_done = 0;

  always #5 clk = ~clk;

  hscc_top i_hscc_top (
    .clk(clk), .srst(srst), .channel_input_pin(pin), .over_temp_trip(ot),
    .dyn_temp_trip(dyn), .inverse_current(inv), .overload_mon(ovl),
    .ground_lost(gnd), .sclk(sclk), .cs_n(cs_n), .reg_valid(rv), .reg_write(rw),
    .register_bank_select(bank), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .channel_output_pin(outp),
    .err_flag(err), .thermal_latch(lat), .pwm_and_mode(mode)
  );

  hscc_host i_hscc_host (.go(go), .sclk(sclk), .cs_n(cs_n), .busy(busy));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_vec(input hscc_vec_t got, input hscc_vec_t exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp_data(input logic [5:0] got, input logic [5:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // an idle edge follows each access so valid is never set twice in one step
  task automatic wr(input logic b, input logic [1:0] a, input logic [5:0] d);
    rv = 1'h1;
    rw = 1'h1;
    bank = b;
    addr = a;
    wd = d;
    step(1);
    rv = 1'h0;
    rw = 1'h0;
    step(1);
  endtask

  task automatic rd(input logic b, input logic [1:0] a, input logic [5:0] exp);
    int i;
    rv = 1'h1;
    rw = 1'h0;
    bank = b;
    addr = a;
    step(1);
    rv = 1'h0;
    for (i = 0; i < 4 && rvalid !== 1'h1; i++) step(1);
    if (rvalid !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: read answer missing", $time);
      results;
    end else begin
      cmp_data(rdata, exp, "read data");
      step(1);
    end
  endtask

  task automatic frame;
    int i;
    go = 1'h1;
    step(1);
    go = 1'h0;
    for (i = 0; i < 200 && busy; i++) step(1);
    if (busy) begin
      miscompares++;
      $display("mismatch at %0t: frame never ended", $time);
      results;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    cmp_vec(outp, 5'h00, "outputs after reset");
    cmp_vec(lat | err, 5'h00, "latches and flags after reset");
    rd(1'h0, 2'h0, 6'h00);
    rd(1'h1, 2'h1, 6'h00);
    rd(1'h1, 2'h2, 6'h00);
    rd(1'h1, 2'h3, 6'h00);
  endtask

  task automatic t_or;
    wr(1'h0, 2'h0, 6'h15);
    pin = 5'h02;
    step(4);
    cmp_vec(outp, 5'h17, "or combine");
    rd(1'h0, 2'h0, 6'h15);
    pin = 5'h00;
    step(4);
    cmp_vec(outp, 5'h15, "bits alone");
  endtask

  task automatic t_and;
    wr(1'h1, 2'h1, 6'h08);
    step(2);
    cmp_data({5'h00, mode}, 6'h01, "and mode");
    pin = 5'h06;
    step(4);
    cmp_vec(outp, 5'h04, "and combine");
    rd(1'h1, 2'h1, 6'h08);
    pin = 5'h1F;
    step(4);
    cmp_vec(outp, 5'h15, "pin gated by bit");
    wr(1'h1, 2'h1, 6'h00);
    pin = 5'h00;
    step(4);
    cmp_vec(outp, 5'h15, "back to or");
  endtask

  task automatic t_ot;
    wr(1'h0, 2'h0, 6'h1F);
    ot = 5'h01;
    step(5);
    cmp_vec(outp, 5'h1E, "trip switches off");
    cmp_vec(lat, 5'h01, "latch set");
    ot = 5'h00;
    step(5);
    cmp_vec(outp, 5'h1E, "held off after cooling");
    wr(1'h1, 2'h2, 6'h00);
    step(3);
    cmp_vec(lat, 5'h01, "zero leaves latch");
    ot = 5'h01;
    step(3);
    wr(1'h1, 2'h2, 6'h01);
    step(3);
    cmp_vec(lat, 5'h01, "still hot");
    cmp_vec(outp, 5'h1E, "still off while hot");
    ot = 5'h00;
    step(4);
    wr(1'h1, 2'h2, 6'h01);
    step(4);
    cmp_vec(lat, 5'h00, "latch cleared");
    cmp_vec(outp, 5'h1F, "channel back");
    rd(1'h1, 2'h0, 6'h01);
    rd(1'h1, 2'h0, 6'h00);
  endtask

  task automatic t_dyn;
    dyn = 5'h04;
    step(5);
    cmp_vec(outp, 5'h1B, "dynamic off");
    cmp_vec(err, 5'h04, "flag set");
    rd(1'h1, 2'h0, 6'h04);
    cmp_vec(err, 5'h04, "set again");
    dyn = 5'h00;
    step(5);
    cmp_vec(outp, 5'h1F, "dynamic over");
    rd(1'h1, 2'h0, 6'h04);
    cmp_vec(err, 5'h00, "read clears");
  endtask

  task automatic t_inv;
    ovl = 5'h08;
    step(5);
    ovl = 5'h00;
    step(4);
    cmp_vec(err, 5'h08, "overload latched");
    inv = 5'h08;
    step(5);
    cmp_vec(err, 5'h00, "inverse clears flag");
    dyn = 5'h08;
    step(5);
    cmp_vec(outp, 5'h1F, "inverse holds state");
    cmp_vec(err, 5'h00, "flag stays clear");
    dyn = 5'h00;
    step(3);
    inv = 5'h00;
    step(5);
    cmp_vec(outp, 5'h1F, "after inverse");
    cmp_vec(err, 5'h00, "no flag after inverse");
  endtask

  task automatic t_gnd;
    gnd = 1'h1;
    step(5);
    cmp_vec(outp, 5'h00, "ground lost");
    gnd = 1'h0;
    step(5);
    cmp_vec(outp, 5'h1F, "ground back");
  endtask

  task automatic t_frame;
    ovl = 5'h02;
    step(5);
    ovl = 5'h00;
    step(4);
    cmp_vec(err, 5'h02, "overload latched");
    frame;
    step(2);
    cmp_vec(err, 5'h00, "frame clears");
  endtask

  task automatic t_rst;
    wr(1'h1, 2'h2, 6'h02);
    step(2);
    cmp_vec(outp, 5'h00, "reset command drops bits");
    rd(1'h0, 2'h0, 6'h00);
    wr(1'h1, 2'h1, 6'h08);
    wr(1'h1, 2'h2, 6'h02);
    rd(1'h1, 2'h1, 6'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    step(12);
    srst = 1'h0;
    step(3);
    t_reset;
    t_or;
    t_and;
    t_ot;
    t_dyn;
    t_inv;
    t_gnd;
    t_frame;
    t_rst;
    results;
  end
endmodule

// ### hw/hscc_chan.sv
// one output channel: request combine, thermal latch, error flag, gate drive
`timescale 1ns/10ps
module hscc_chan (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_pin,
  input wire logic channel_on_bit,
  input wire logic and_mode,
  input wire logic over_temp,
  input wire logic dyn_temp,
  input wire logic inverse,
  input wire logic ground_lost,
  input wire logic overload,
  input wire logic clear_latch,
  input wire logic clear_err,
  output logic gate,
  output logic latch,
  output logic err
);
  logic gate_reg;
  logic gate_next;
  logic latch_reg;
  logic latch_next;
  logic err_reg;
  logic err_next;
  logic request;
  logic force_off;
  logic err_set;

  always_comb begin
    // pin gates the bit in and-mode so a pulse train can chop the channel
    request = and_mode ? (in_pin & channel_on_bit) : (in_pin | channel_on_bit); // R2 R3
    // a trip still present when the clear arrives keeps the latch set
    latch_next = over_temp | (latch_reg & ~clear_latch); // R5 R6
    force_off = ground_lost | over_temp | latch_reg | dyn_temp; // R7 R10 R14
    // inverse current freezes the switch state as it stands
    gate_next = inverse ? gate_reg : (request & ~force_off); // R9 R14
    err_set = dyn_temp | overload | latch_reg; // R8 R13
    // set beats the read or frame clear; inverse current overrides both
    err_next = inverse ? 1'h0 : (err_set | (err_reg & ~clear_err)); // R8 R9
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gate_reg <= 1'h0;
      latch_reg <= 1'h0;
      err_reg <= 1'h0;
    end else begin
      gate_reg <= gate_next;
      latch_reg <= latch_next;
      err_reg <= err_next;
    end
  end

  assign gate = gate_reg;
  assign latch = latch_reg;
  assign err = err_reg;
endmodule

// ### hw/hscc_pkg.sv
// shared constants for the high-side channel control block
package hscc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 5;
  localparam int DATA_W = 6;
  localparam int ADDR_W = 2;

  // ----------------------------------------------------------------
  // register decode: bank select plus address within bank one
  // ----------------------------------------------------------------
  localparam logic BANK_OUT = 1'h0;
  localparam logic BANK_CFG = 1'h1;
  localparam logic [ADDR_W-1:0] ADDR_DIAG = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_HWCFG = 2'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BOOST_BIT = 5;
  localparam int PWM_BIT = 3;
  localparam int CLR_LATCH_BIT = 0;
  localparam int RST_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0] OUT_RESET = 5'h00;
  localparam logic PWM_RESET = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 6'h00;

  // ----------------------------------------------------------------
  // serial clock edge after which the diagnosis flags are cleared
  // ----------------------------------------------------------------
  localparam logic [1:0] DIAG_CLR_EDGE = 2'h2;
  localparam logic [1:0] EDGE_MAX = 2'h3;
endpackage

// ### hw/hscc_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module hscc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds the second stage only
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ### hw/hscc_top.sv
// top of the high-side channel control block: registers, serial frame clear, channels
//
// Function
// R1: bits 0 to 4 of the output register switch their channel on at one and off at zero.
// R2: with the combine mode at zero a channel is on when its pin is high or its bit is set.
// R3: with the combine mode at one a channel is on only when its pin is high and its bit is set.
// R4: the host writes zero to output register bit 5, which reads back as undefined.
// R5: each channel's over-temperature trip switches it off and sets a latch holding it off.
// R6: a latched channel returns only after cooling and a clear command, which clears all latches.
// R7: a dynamic temperature trip switches its channel off while it lasts.
// R8: a dynamic shutdown sets the error flag, a read clears it, and it sets again if still active.
// R9: inverse current clears the channel's error flag and holds its on or off state.
// R10: loss of device ground sends every channel off or keeps it off; the code leaves a channel with inverse current holding its on or off state.
// R11: five independent channels, each switched by its pin or by its register bit.
// R12: the clear command is bit 0 of the hardware configuration register; zero does nothing.
// R13: overload events latch into the error flags, cleared by each diagnosis word sent.
// R14: gate drive is the combined request forced low by a thermal latch or dynamic shutdown.
`timescale 1ns/10ps
module hscc_top #(
  parameter int NUM_CH = hscc_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_CH-1:0] channel_input_pin,
  input wire logic [NUM_CH-1:0] over_temp_trip,
  input wire logic [NUM_CH-1:0] dyn_temp_trip,
  input wire logic [NUM_CH-1:0] inverse_current,
  input wire logic [NUM_CH-1:0] overload_mon,
  input wire logic ground_lost,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic register_bank_select,
  input wire logic [hscc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [hscc_pkg::DATA_W-1:0] reg_wdata,
  output logic [hscc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic [NUM_CH-1:0] channel_output_pin,
  output logic [NUM_CH-1:0] err_flag,
  output logic [NUM_CH-1:0] thermal_latch,
  output logic pwm_and_mode
);
  // ----------------------------------------------------------------
  // synchronise everything that comes from pins or analogue detectors
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5 * NUM_CH + 3;

  logic [SYNC_W-1:0] sync_out;
  logic [NUM_CH-1:0] s_pin;
  logic [NUM_CH-1:0] s_ot;
  logic [NUM_CH-1:0] s_dyn;
  logic [NUM_CH-1:0] s_inv;
  logic [NUM_CH-1:0] s_ovl;
  logic s_gnd;
  logic s_sclk;
  logic s_csn;

  hscc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({channel_input_pin, over_temp_trip, dyn_temp_trip, inverse_current,
      overload_mon, ground_lost, sclk, cs_n}),
    .sync_out(sync_out)
  );

  assign {s_pin, s_ot, s_dyn, s_inv, s_ovl, s_gnd, s_sclk, s_csn} = sync_out;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] out_reg;
  logic [NUM_CH-1:0] out_next;
  logic pwm_reg;
  logic pwm_next;
  logic [hscc_pkg::DATA_W-1:0] rdata_reg;
  logic [hscc_pkg::DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic clear_thermal_latch;
  logic diag_rd;
  logic hit_out;
  logic hit_mode;
  logic hit_hwcfg;
  logic hit_diag;

  always_comb begin
    out_next = out_reg;
    pwm_next = pwm_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'h0;
    clear_thermal_latch = 1'h0;
    diag_rd = 1'h0;
    hit_out = register_bank_select == hscc_pkg::BANK_OUT;
    hit_mode = (register_bank_select == hscc_pkg::BANK_CFG)
      && (reg_addr == hscc_pkg::ADDR_MODE);
    hit_hwcfg = (register_bank_select == hscc_pkg::BANK_CFG)
      && (reg_addr == hscc_pkg::ADDR_HWCFG);
    hit_diag = (register_bank_select == hscc_pkg::BANK_CFG) && (reg_addr == hscc_pkg::ADDR_DIAG);
    if (reg_valid && reg_write) begin
      if (hit_out) begin
        // boost bit is dropped: it only burns supply current
        out_next = reg_wdata[NUM_CH-1:0]; // R1 R4
      end
      if (hit_mode) begin
        pwm_next = reg_wdata[hscc_pkg::PWM_BIT]; // R2 R3
      end
      if (hit_hwcfg) begin
        clear_thermal_latch = reg_wdata[hscc_pkg::CLR_LATCH_BIT]; // R12
        if (reg_wdata[hscc_pkg::RST_BIT]) begin
          out_next = hscc_pkg::OUT_RESET;
          pwm_next = hscc_pkg::PWM_RESET;
        end
      end
    end else if (reg_valid) begin
      rvalid_next = 1'h1;
      rdata_next = hscc_pkg::RDATA_RESET;
      if (hit_out) begin
        rdata_next[NUM_CH-1:0] = out_reg; // R4
      end
      if (hit_mode) begin
        rdata_next[hscc_pkg::PWM_BIT] = pwm_reg;
      end
      if (hit_diag) begin
        rdata_next[NUM_CH-1:0] = err_flag;
        diag_rd = 1'h1; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_reg <= hscc_pkg::OUT_RESET;
      pwm_reg <= hscc_pkg::PWM_RESET;
      rdata_reg <= hscc_pkg::RDATA_RESET;
      rvalid_reg <= 1'h0;
    end else begin
      out_reg <= out_next;
      pwm_reg <= pwm_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign pwm_and_mode = pwm_reg;

  // ----------------------------------------------------------------
  // serial frame watcher: clears the flags as the diagnosis word goes out
  // ----------------------------------------------------------------
  logic sclk_prev_reg;
  logic sclk_prev_next;
  logic [1:0] edge_cnt_reg;
  logic [1:0] edge_cnt_next;
  logic sclk_rise;
  logic frame_clr;

  always_comb begin
    sclk_prev_next = s_sclk;
    sclk_rise = s_sclk & ~sclk_prev_reg & ~s_csn;
    edge_cnt_next = edge_cnt_reg;
    if (s_csn) begin
      edge_cnt_next = '0;
    end else if (sclk_rise && (edge_cnt_reg != hscc_pkg::EDGE_MAX)) begin
      edge_cnt_next = edge_cnt_reg + 2'h1;
    end
    // counter saturates, so one clear per frame however long it runs
    frame_clr = sclk_rise && ((edge_cnt_reg + 2'h1) == hscc_pkg::DIAG_CLR_EDGE); // R13
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_prev_reg <= 1'h0;
      edge_cnt_reg <= '0;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic clear_err;

  assign clear_err = diag_rd | frame_clr;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan // R11
    hscc_chan u_chan (
      .clk(clk),
      .srst(srst),
      .in_pin(s_pin[ch]),
      .channel_on_bit(out_reg[ch]),
      .and_mode(pwm_reg),
      .over_temp(s_ot[ch]),
      .dyn_temp(s_dyn[ch]),
      .inverse(s_inv[ch]),
      .ground_lost(s_gnd),
      .overload(s_ovl[ch]),
      .clear_latch(clear_thermal_latch),
      .clear_err(clear_err),
      .gate(channel_output_pin[ch]),
      .latch(thermal_latch[ch]),
      .err(err_flag[ch])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_out_write;
    @(posedge clk) disable iff (srst)
    (reg_valid && reg_write && hit_out) |=> (out_reg == $past(reg_wdata[NUM_CH-1:0]));
  endproperty
  a_out_write: assert property (p_out_write) else $error("output register write lost"); // R1

  property p_gate_or;
    @(posedge clk) disable iff (srst)
    (!pwm_reg && !s_inv[0] && !s_gnd && !thermal_latch[0] && !s_ot[0] && !s_dyn[0])
      |=> (channel_output_pin[0] == ($past(s_pin[0]) | $past(out_reg[0])));
  endproperty
  a_gate_or: assert property (p_gate_or) else $error("or-mode gate wrong"); // R2

  property p_gate_and;
    @(posedge clk) disable iff (srst)
    (pwm_reg && !s_inv[0] && !s_gnd && !thermal_latch[0] && !s_ot[0] && !s_dyn[0])
      |=> (channel_output_pin[0] == ($past(s_pin[0]) & $past(out_reg[0])));
  endproperty
  a_gate_and: assert property (p_gate_and) else $error("and-mode gate wrong"); // R3

  property p_ot_latch;
    @(posedge clk) disable iff (srst)
    (s_ot[0] && !s_inv[0]) |=> (thermal_latch[0] && !channel_output_pin[0]);
  endproperty
  a_ot_latch: assert property (p_ot_latch) else $error("over-temperature not latched off"); // R5

  property p_latch_hold;
    @(posedge clk) disable iff (srst)
    (thermal_latch[0] && !clear_thermal_latch) |=> thermal_latch[0] [*1] ##1 (thermal_latch[0]
      || clear_thermal_latch || $past(clear_thermal_latch));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("thermal latch released itself"); // R6

  property p_latch_clear_all;
    @(posedge clk) disable iff (srst)
    (clear_thermal_latch && (s_ot == '0)) |=> (thermal_latch == '0);
  endproperty
  a_latch_clear_all: assert property (p_latch_clear_all) else $error("clear left a latch"); // R12

  property p_clear_zero;
    @(posedge clk) disable iff (srst)
    (reg_valid && reg_write && hit_hwcfg && !reg_wdata[hscc_pkg::CLR_LATCH_BIT]
      && thermal_latch[0]) |=> thermal_latch[0];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared a latch"); // R12

  property p_dyn_off;
    @(posedge clk) disable iff (srst)
    (s_dyn[0] && !s_inv[0]) |=> (err_flag[0] && !channel_output_pin[0]);
  endproperty
  a_dyn_off: assert property (p_dyn_off) else $error("dynamic shutdown missing"); // R7 R8

  property p_inv_hold;
    @(posedge clk) disable iff (srst)
    s_inv[0] |=> (!err_flag[0] && (channel_output_pin[0] == $past(channel_output_pin[0])));
  endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("inverse current did not hold state"); // R9

  property p_gnd_off;
    @(posedge clk) disable iff (srst)
    (s_gnd && (s_inv == '0)) |=> (channel_output_pin == '0);
  endproperty
  a_gnd_off: assert property (p_gnd_off) else $error("channel on after ground loss"); // R10

  property p_flag_clear;
    @(posedge clk) disable iff (srst)
    (clear_err && ((s_dyn | s_ovl | thermal_latch) == '0)) |=> (err_flag == '0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("error flags not cleared"); // R8 R13

  property p_ovl_set;
    @(posedge clk) disable iff (srst)
    (s_ovl[0] && !s_inv[0]) |=> err_flag[0];
  endproperty
  a_ovl_set: assert property (p_ovl_set) else $error("overload not latched"); // R13

  property p_latch_gate;
    @(posedge clk) disable iff (srst)
    thermal_latch[0] && !s_inv[0] |=> !channel_output_pin[0];
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("gate on while latched"); // R14

  property p_out_read;
    @(posedge clk) disable iff (srst)
    (reg_valid && !reg_write && hit_out)
      |=> (reg_rvalid && (reg_rdata[NUM_CH-1:0] == $past(out_reg)));
  endproperty
  a_out_read: assert property (p_out_read) else $error("output register read wrong"); // R1

  property p_diag_read;
    @(posedge clk) disable iff (srst)
    (reg_valid && !reg_write && hit_diag)
      |=> (reg_rvalid && (reg_rdata[NUM_CH-1:0] == $past(err_flag)));
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("error flag read wrong"); // R8
endmodule
